// ==== rtl/ufi_cfg.svh ====
/*
 Constants of the buffered serial port interrupt block.
 Assumes a 16x receive baud tick and a 32-bit AXI4-Lite slave.
*/
`ifndef UFI_CFG_SVH
`define UFI_CFG_SVH
`define UFI_IX_HI      7
`define UFI_IX_LO      2
`define UFI_IX_BUF     6'h00
`define UFI_IX_DLM     6'h01
`define UFI_IX_IER     6'h04
`define UFI_IX_IIR     6'h08
`define UFI_IX_LCR     6'h0C
`define UFI_IX_LTR     6'h10
`define UFI_IX_LSR     6'h14
`define UFI_IX_SCR     6'h1C
`define UFI_IX_CKG     6'h20
`define UFI_IX_CKD     6'h24
`define UFI_ID_NONE    4'h1
`define UFI_ID_LS      4'h6
`define UFI_ID_RDA     4'h4
`define UFI_ID_TMO     4'hC
`define UFI_ID_THR     4'h2
`define UFI_IE_RDA     0
`define UFI_IE_THR     1
`define UFI_IE_LS      2
`define UFI_IER_MASK   8'h07
`define UFI_LTR_MASK   8'h10
`define UFI_CKG_MASK   8'h01
`define UFI_CKG_EN     0
`define UFI_LBON       4
`define UFI_FCR_EN     0
`define UFI_FCR_RXCLR  1
`define UFI_FCR_TXCLR  2
`define UFI_FCR_TRG_HI 7
`define UFI_FCR_TRG_LO 6
`define UFI_LCR_DLAB   7
`define UFI_LCR_PEN    3
`define UFI_LCR_STOP   2
`define UFI_LCR_LEN_HI 1
`define UFI_TRIG_1     1
`define UFI_TRIG_4     4
`define UFI_TRIG_8     8
`define UFI_TRIG_14    14
`define UFI_BASE_BITS  7
`define UFI_OVS        16
`define UFI_TMO_CHARS  4
`define UFI_TWO_BYTES  2
`define UFI_RESP_OKAY  2'h0
`define UFI_RESP_SLV   2'h2
`endif

// ==== rtl/ufi_pkg.sv ====
/*
 Types of the buffered serial port interrupt block.
 Assumes nothing beyond the constants header.
*/
package ufi_pkg;
    typedef enum logic {
        TXD_IDLE,
        TXD_WAIT
    } ufi_txd_t;
endpackage

// ==== rtl/ufi_top.sv ====
/*
 FIFO, interrupt and register logic of a 16-deep buffered serial port.
 Assumes the shifters outside hand over whole characters and a 16x baud tick.
*/
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "ufi_cfg.svh"
module ufi_top #(
    parameter int DEPTH = 16,
    parameter int AW    = 8
) (
    input  wire logic          I_CORE_CLK,
    input  wire logic          I_RST,
    input  wire logic [AW-1:0] I_AWADDR,
    input  wire logic          I_AWVALID,
    output logic               O_AWREADY,
    input  wire logic [31:0]   I_WDATA,
    input  wire logic [3:0]    I_WSTRB,
    input  wire logic          I_WVALID,
    output logic               O_WREADY,
    output logic [1:0]         O_BRESP,
    output logic               O_BVALID,
    input  wire logic          I_BREADY,
    input  wire logic [AW-1:0] I_ARADDR,
    input  wire logic          I_ARVALID,
    output logic               O_ARREADY,
    output logic [31:0]        O_RDATA,
    output logic [1:0]         O_RRESP,
    output logic               O_RVALID,
    input  wire logic          I_RREADY,
    input  wire logic          I_RX_VALID,
    input  wire logic [7:0]    I_RX_DATA,
    input  wire logic [2:0]    I_RX_ERR,
    input  wire logic          I_BAUD_TICK,
    output logic [7:0]         O_TX_DATA,
    output logic               O_TX_VALID,
    input  wire logic          I_TX_READY,
    input  wire logic          I_TX_IDLE,
    output logic               O_IRQ,
    output logic [7:0]         O_LINE_CTRL,
    output logic [15:0]        O_BAUD_DIV,
    output logic               O_LOOPBACK,
    output logic               O_CLK_EN,
    output logic [7:0]         O_CLK_DIV
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam int TW = 12;

    logic [7:0]         ier_q, lcr_q, ltr_q, scr_q, ckg_q, ckd_q, dll_q, dlm_q;
    logic               fen_q;
    logic [1:0]         tsel_q;
    logic [7:0]         rx_mem [DEPTH];
    logic [7:0]         tx_mem [DEPTH];
    logic [PW-1:0]      rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    logic [CW-1:0]      rx_cnt_q, tx_cnt_q, cap, trig;
    logic [3:0]         ls_q;
    logic [3:0]         char_bits, iid;
    logic [TW-1:0]      tmo_cnt_q, tmo_lim, dly_cnt_q, dly_lim;
    logic               tmo_q, two_q, imm_q, thr_q, empty_prev_q, irq_q;
    ufi_pkg::ufi_txd_t  txd_q;
    logic               aw_v_q, w_v_q, bv_q, rv_q, w_s_q;
    logic [5:0]         aw_ix_q, ar_ix;
    logic [7:0]         w_d_q, rd_val;
    logic [1:0]         bresp_q, rresp_q;
    logic [31:0]        rdata_q;
    logic               wr_go, rd_go, wr_ok, rd_ok, wr_en, dlab;
    logic               rx_push, rx_pop, tx_push, tx_pop, rx_clr, tx_clr;
    logic               fcr_wr, fen_chg, lsr_rd, iir_rd_thr;
    logic               ls_act, rda_act, tmo_act, thr_act;
    logic               tx_empty, empty_rise, no_delay, thr_set, tmo_hit;

    assign dlab      = lcr_q[`UFI_LCR_DLAB];
    assign ar_ix     = I_ARADDR[`UFI_IX_HI:`UFI_IX_LO];
    assign O_AWREADY = !aw_v_q && !bv_q;
    assign O_WREADY  = !w_v_q && !bv_q;
    assign O_ARREADY = !rv_q;
    assign wr_go     = aw_v_q && w_v_q && !bv_q;
    assign rd_go     = I_ARVALID && !rv_q;
    assign wr_en     = wr_go && w_s_q;

    // write side of the bus: address and data parked until both are in
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            aw_v_q  <= 1'b0;
            w_v_q   <= 1'b0;
            bv_q    <= 1'b0;
            aw_ix_q <= '0;
            w_d_q   <= '0;
            w_s_q   <= 1'b0;
            bresp_q <= `UFI_RESP_OKAY;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_v_q  <= 1'b1;
                aw_ix_q <= I_AWADDR[`UFI_IX_HI:`UFI_IX_LO];
            end
            if (I_WVALID && O_WREADY) begin
                w_v_q <= 1'b1;
                w_d_q <= I_WDATA[7:0];
                w_s_q <= I_WSTRB[0];
            end
            if (wr_go) begin
                aw_v_q  <= 1'b0;
                w_v_q   <= 1'b0;
                bv_q    <= 1'b1;
                bresp_q <= wr_ok ? `UFI_RESP_OKAY : `UFI_RESP_SLV;
            end else if (bv_q && I_BREADY) begin
                bv_q <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (aw_ix_q)
            `UFI_IX_BUF, `UFI_IX_DLM, `UFI_IX_IER, `UFI_IX_IIR, `UFI_IX_LCR,
            `UFI_IX_LTR, `UFI_IX_SCR, `UFI_IX_CKG, `UFI_IX_CKD: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    assign tx_push = wr_en && aw_ix_q == `UFI_IX_BUF && !dlab && tx_cnt_q != cap;
    assign fcr_wr  = wr_en && aw_ix_q == `UFI_IX_IIR;
    assign fen_chg = fcr_wr && (w_d_q[`UFI_FCR_EN] != fen_q);
    // changing mode always flushes; the clear bits need the enable bit set
    assign rx_clr = fcr_wr && (fen_chg || (w_d_q[`UFI_FCR_EN] && w_d_q[`UFI_FCR_RXCLR]));
    assign tx_clr = fcr_wr && (fen_chg || (w_d_q[`UFI_FCR_EN] && w_d_q[`UFI_FCR_TXCLR]));

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ier_q  <= '0;
            lcr_q  <= '0;
            ltr_q  <= '0;
            scr_q  <= '0;
            ckg_q  <= '0;
            ckd_q  <= '0;
            dll_q  <= '0;
            dlm_q  <= '0;
            fen_q  <= 1'b0;
            tsel_q <= '0;
        end else if (wr_en) begin
            unique case (aw_ix_q)
                `UFI_IX_BUF: if (dlab) dll_q <= w_d_q;
                `UFI_IX_DLM: dlm_q <= w_d_q;
                `UFI_IX_IER: ier_q <= w_d_q & `UFI_IER_MASK;
                `UFI_IX_IIR: begin
                    fen_q <= w_d_q[`UFI_FCR_EN];
                    if (w_d_q[`UFI_FCR_EN]) begin
                        tsel_q <= w_d_q[`UFI_FCR_TRG_HI:`UFI_FCR_TRG_LO];
                    end
                end
                `UFI_IX_LCR: lcr_q <= w_d_q;
                `UFI_IX_LTR: ltr_q <= w_d_q & `UFI_LTR_MASK;
                `UFI_IX_SCR: scr_q <= w_d_q;
                `UFI_IX_CKG: ckg_q <= w_d_q & `UFI_CKG_MASK;
                `UFI_IX_CKD: ckd_q <= w_d_q;
                default: ;
            endcase
        end
    end

    // without fifos the port behaves as a single holding byte each way
    assign cap = fen_q ? CW'(DEPTH) : CW'(`UFI_TRIG_1);

    always_comb begin
        unique case (tsel_q)
            2'b00: trig = CW'(`UFI_TRIG_1);
            2'b01: trig = CW'(`UFI_TRIG_4);
            2'b10: trig = CW'(`UFI_TRIG_8);
            2'b11: trig = CW'(`UFI_TRIG_14);
        endcase
        if (!fen_q) begin
            trig = CW'(`UFI_TRIG_1);
        end
    end

    assign rx_push = I_RX_VALID && rx_cnt_q != cap;
    assign rx_pop  = rd_go && ar_ix == `UFI_IX_BUF && !dlab && rx_cnt_q != '0;
    assign tx_pop  = O_TX_VALID && I_TX_READY;

    always_ff @(posedge I_CORE_CLK) begin
        if (rx_push) begin
            rx_mem[rx_wp_q] <= I_RX_DATA;
        end
        if (tx_push) begin
            tx_mem[tx_wp_q] <= w_d_q;
        end
    end

    // pointer wrap relies on DEPTH being a power of two
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
        end else if (rx_clr) begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
        end else begin
            if (rx_push) rx_wp_q <= rx_wp_q + 1'b1;
            if (rx_pop) rx_rp_q <= rx_rp_q + 1'b1;
            rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
        end else if (tx_clr) begin
            tx_wp_q  <= '0;
            tx_rp_q  <= '0;
            tx_cnt_q <= '0;
        end else begin
            if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
            if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
            tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
        end
    end

    assign lsr_rd = rd_go && ar_ix == `UFI_IX_LSR;

    // line errors {break, framing, parity, overrun}; new errors win over the read
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            ls_q <= '0;
        end else begin
            ls_q <= (lsr_rd ? 4'h0 : ls_q)
                  | {rx_push ? I_RX_ERR : 3'h0, I_RX_VALID && !rx_push};
        end
    end

    // frame length in bits: start, data, parity, one or two stops
    assign char_bits = 4'(`UFI_BASE_BITS) + {2'b00, lcr_q[`UFI_LCR_LEN_HI:0]}
                     + {3'b000, lcr_q[`UFI_LCR_PEN]} + {3'b000, lcr_q[`UFI_LCR_STOP]};
    assign tmo_lim   = TW'(char_bits * `UFI_OVS * `UFI_TMO_CHARS);
    assign dly_lim   = TW'((char_bits - 4'h1) * `UFI_OVS);
    assign tmo_hit   = fen_q && rx_cnt_q != '0 && tmo_cnt_q >= tmo_lim;

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            tmo_cnt_q <= '0;
        end else if (rx_push || rx_pop || rx_cnt_q == '0) begin
            tmo_cnt_q <= '0;
        end else if (I_BAUD_TICK && tmo_cnt_q < tmo_lim) begin
            tmo_cnt_q <= tmo_cnt_q + 1'b1;
        end
    end

    // a read both ends the timeout and restarts the idle count
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            tmo_q <= 1'b0;
        end else if (rx_pop || rx_clr) begin
            tmo_q <= 1'b0;
        end else if (tmo_hit) begin
            tmo_q <= 1'b1;
        end
    end

    assign tx_empty   = tx_cnt_q == '0;
    assign empty_rise = tx_empty && !empty_prev_q;
    assign no_delay   = !fen_q || two_q || imm_q;
    assign thr_set    = (empty_rise && no_delay)
                     || (txd_q == ufi_pkg::TXD_WAIT && tx_empty && dly_cnt_q >= dly_lim);

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            empty_prev_q <= 1'b0;
            two_q        <= 1'b0;
        end else begin
            // a flush empties the fifo afresh, so it must raise the empty edge again
            empty_prev_q <= tx_empty && !tx_clr;
            if (tx_cnt_q >= CW'(`UFI_TWO_BYTES)) begin
                two_q <= 1'b1;
            end else if (empty_rise) begin
                two_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            imm_q <= 1'b1;
        end else if (fen_chg) begin
            imm_q <= 1'b1;
        end else if (thr_set) begin
            imm_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            txd_q     <= ufi_pkg::TXD_IDLE;
            dly_cnt_q <= '0;
        end else begin
            unique case (txd_q)
                ufi_pkg::TXD_IDLE: begin
                    dly_cnt_q <= '0;
                    if (empty_rise && !no_delay) begin
                        txd_q <= ufi_pkg::TXD_WAIT;
                    end
                end
                ufi_pkg::TXD_WAIT: begin
                    if (!tx_empty || thr_set) begin
                        txd_q <= ufi_pkg::TXD_IDLE;
                    end else if (I_BAUD_TICK) begin
                        dly_cnt_q <= dly_cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    assign iir_rd_thr = rd_go && ar_ix == `UFI_IX_IIR && iid == `UFI_ID_THR;

    // set wins over a holding write or ident read in the same cycle
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            thr_q <= 1'b0;
        end else if (thr_set) begin
            thr_q <= 1'b1;
        end else if (tx_push || iir_rd_thr) begin
            thr_q <= 1'b0;
        end
    end

    // each source gated by an enable, the timeout sharing the rx data one, so either side may be polled
    assign ls_act  = ier_q[`UFI_IE_LS] && ls_q != '0;
    assign rda_act = ier_q[`UFI_IE_RDA] && rx_cnt_q >= trig;
    assign tmo_act = ier_q[`UFI_IE_RDA] && tmo_q;
    assign thr_act = ier_q[`UFI_IE_THR] && thr_q;

    always_comb begin
        if (ls_act) iid = `UFI_ID_LS;
        else if (rda_act) iid = `UFI_ID_RDA;
        else if (tmo_act) iid = `UFI_ID_TMO;
        else if (thr_act) iid = `UFI_ID_THR;
        else iid = `UFI_ID_NONE;
    end

    always_comb begin
        rd_val = '0;
        rd_ok  = 1'b1;
        unique case (ar_ix)
            `UFI_IX_BUF: rd_val = dlab ? dll_q : rx_mem[rx_rp_q];
            `UFI_IX_DLM: rd_val = dlm_q;
            `UFI_IX_IER: rd_val = ier_q;
            `UFI_IX_IIR: rd_val = {fen_q, fen_q, 2'b00, iid};
            `UFI_IX_LCR: rd_val = lcr_q;
            `UFI_IX_LTR: rd_val = ltr_q;
            `UFI_IX_LSR: rd_val = {fen_q && ls_q[3:1] != '0, tx_empty && I_TX_IDLE,
                                   tx_empty, ls_q, rx_cnt_q != '0};
            `UFI_IX_SCR: rd_val = scr_q;
            `UFI_IX_CKG: rd_val = ckg_q;
            `UFI_IX_CKD: rd_val = ckd_q;
            default: rd_ok = 1'b0;
        endcase
    end

    // ident captured in one edge, so later events wait for the next read
    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            rv_q    <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `UFI_RESP_OKAY;
        end else if (rd_go) begin
            rv_q    <= 1'b1;
            rdata_q <= {24'h0, rd_val};
            rresp_q <= rd_ok ? `UFI_RESP_OKAY : `UFI_RESP_SLV;
        end else if (rv_q && I_RREADY) begin
            rv_q <= 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ls_act || rda_act || tmo_act || thr_act;
        end
    end

    assign O_BVALID    = bv_q;
    assign O_BRESP     = bresp_q;
    assign O_RVALID    = rv_q;
    assign O_RDATA     = rdata_q;
    assign O_RRESP     = rresp_q;
    assign O_TX_DATA   = tx_mem[tx_rp_q];
    assign O_TX_VALID  = !tx_empty;
    assign O_IRQ       = irq_q;
    assign O_LINE_CTRL = lcr_q;
    assign O_BAUD_DIV  = {dlm_q, dll_q};
    assign O_LOOPBACK  = ltr_q[`UFI_LBON];
    assign O_CLK_EN    = ckg_q[`UFI_CKG_EN];
    assign O_CLK_DIV   = ckd_q;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    AST_RDA_ID: assert property (rda_act && !ls_act |-> iid == `UFI_ID_RDA)
        else $error("rx available not identified");
    AST_LS_PRIO: assert property (ls_act && rda_act |-> iid == `UFI_ID_LS)
        else $error("line status lost priority");
    AST_IRQ_OUT: assert property ((rda_act || thr_act) |=> O_IRQ)
        else $error("irq output missing");
    AST_DR_SET: assert property (rx_push && !rx_clr |=> rx_cnt_q != '0)
        else $error("pushed char not held");
    AST_TMO_CLR: assert property (tmo_q && rx_pop |=> !tmo_q)
        else $error("timeout not cleared by read");
    AST_TMO_NEED: assert property ($rose(tmo_q) |-> $past(rx_cnt_q) != '0
                                   && $past(tmo_cnt_q) >= $past(tmo_lim))
        else $error("timeout without idle interval");
    AST_THR_CLR: assert property (tx_push && !thr_set |=> !thr_q)
        else $error("holding write left empty irq");
    AST_TRIG14: assert property (fen_q && tsel_q == 2'b11 && ier_q[`UFI_IE_RDA]
                                 |-> rda_act == (rx_cnt_q >= CW'(`UFI_TRIG_14)))
        else $error("trigger select wrong");
    AST_FEN_FLUSH: assert property (fen_chg |=> rx_cnt_q == '0 && tx_cnt_q == '0)
        else $error("mode change kept data");
    AST_IDLE_ID: assert property (!ls_act && !rda_act && !tmo_act && !thr_act
                                  |-> iid == `UFI_ID_NONE)
        else $error("idle code wrong");
    AST_NODLY: assert property (empty_rise && imm_q |=> thr_q)
        else $error("first tx irq delayed");
endmodule // ufi_top

// ==== verif/tb_top.sv ====
/*
 Self-checking bench of the buffered serial port interrupt block.
 Assumes ufi_far as remote end; registers reached over AXI4-Lite from here.
*/
`timescale 1ns/1ps
`include "ufi_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, tick_en = 1'b0, tx_go = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rxv, tick, txv, txr, txi, irq;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata;
    logic [7:0]  rxd, txd, rd;
    logic [2:0]  rxe;
    logic [7:0]  line_control, ckdv;
    logic [15:0] bdiv;
    logic        lb, cken;
    int          errors = 0;
    int          checks = 0;
    int          trg [4] = '{`UFI_TRIG_1, `UFI_TRIG_4, `UFI_TRIG_8, `UFI_TRIG_14};
    ufi_top #(.DEPTH(16), .AW(8)) DUT (
        .I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_RX_VALID(rxv),
        .I_RX_DATA(rxd), .I_RX_ERR(rxe), .I_BAUD_TICK(tick), .O_TX_DATA(txd),
        .O_TX_VALID(txv), .I_TX_READY(txr), .I_TX_IDLE(txi), .O_IRQ(irq),
        .O_LINE_CTRL(line_control), .O_BAUD_DIV(bdiv), .O_LOOPBACK(lb), .O_CLK_EN(cken),
        .O_CLK_DIV(ckdv)
    );
    ufi_far u_far (.i_clk(clk), .i_tick_en(tick_en), .i_tx_go(tx_go), .o_rx_valid(rxv),
        .o_rx_data(rxd), .o_rx_err(rxe), .o_tick(tick), .o_tx_ready(txr), .o_tx_idle(txi));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic hang();
        errors++;
        wrap_up();
    endtask
    // handshakes sampled at the falling edge, released after the rising one
    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        logic at, wt, bt;
        @(posedge clk);
        awaddr <= {ix, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid;
            rs = bresp;
            @(posedge clk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
            if (bt) begin
                bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    task automatic rdx(input logic [5:0] ix);
        logic at, rt;
        @(posedge clk);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            at = arvalid && arready;
            rt = rvalid;
            rd = rdata[7:0];
            rs = rresp;
            @(posedge clk);
            if (at) arvalid <= 1'b0;
            if (rt) begin
                rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask
    task automatic ck(input logic [5:0] ix, input logic [7:0] e);
        rdx(ix);
        `CHK($sformatf("reg%0h", ix), e, rd)
    endtask
    task automatic ckirq(input logic e);
        repeat (3) @(negedge clk);
        `CHK("irq", e, irq)
    endtask
    task automatic drain();
        @(posedge clk) tx_go <= 1'b1;
        for (int n = 0; n < 50 && txv; n++) @(negedge clk);
        @(posedge clk) tx_go <= 1'b0;
        if (txv) hang();
    endtask
    task automatic t_trig();
        for (int i = 0; i < 4; i++) begin
            wr(`UFI_IX_IIR, {i[1:0], 6'h07});
            wr(`UFI_IX_IER, 8'h01);
            for (int k = 0; k < trg[i]; k++) begin
                ck(`UFI_IX_IIR, 8'hC1);
                u_far.send(k[7:0], 3'h0);
            end
            ck(`UFI_IX_IIR, 8'hC4);
            ckirq(1'b1);
            ck(`UFI_IX_BUF, 8'h00);
            ck(`UFI_IX_IIR, 8'hC1);
            ckirq(1'b0);
            wr(`UFI_IX_IER, 8'h00);
            u_far.send(8'h3C, 3'h0);
            ckirq(1'b0);
            rdx(`UFI_IX_LSR);
            `CHK("ready", 1'b1, rd[0])
            wr(`UFI_IX_IIR, 8'h00);
            rdx(`UFI_IX_LSR);
            `CHK("ready", 1'b0, rd[0])
        end
    endtask
    task automatic t_ls();
        wr(`UFI_IX_IIR, 8'h07);
        wr(`UFI_IX_IER, 8'h07);
        u_far.send(8'h55, 3'h2);
        ck(`UFI_IX_IIR, 8'hC6);
        ck(`UFI_IX_LSR, 8'hE9);
        ck(`UFI_IX_IIR, 8'hC4);
        ck(`UFI_IX_BUF, 8'h55);
        ck(`UFI_IX_IIR, 8'hC2);
        ck(`UFI_IX_IIR, 8'hC1);
        wr(`UFI_IX_IER, 8'h00);
    endtask
    // ten-bit characters: four of them are 640 ticks, 1280 cycles
    task automatic t_tmo();
        wr(`UFI_IX_IIR, 8'h87);
        wr(`UFI_IX_IER, 8'h01);
        @(posedge clk) tick_en <= 1'b1;
        u_far.send(8'h11, 3'h0);
        u_far.send(8'h22, 3'h0);
        repeat (1200) @(posedge clk);
        ck(`UFI_IX_IIR, 8'hC1);
        repeat (160) @(posedge clk);
        ck(`UFI_IX_IIR, 8'hCC);
        ckirq(1'b1);
        ck(`UFI_IX_BUF, 8'h11);
        ck(`UFI_IX_IIR, 8'hC1);
        repeat (1200) @(posedge clk);
        ck(`UFI_IX_IIR, 8'hC1);
        repeat (160) @(posedge clk);
        ck(`UFI_IX_IIR, 8'hCC);
        ck(`UFI_IX_BUF, 8'h22);
        u_far.send(8'h33, 3'h0);
        repeat (1000) @(posedge clk);
        u_far.send(8'h44, 3'h0);
        repeat (1000) @(posedge clk);
        ck(`UFI_IX_IIR, 8'hC1);
        repeat (400) @(posedge clk);
        ck(`UFI_IX_IIR, 8'hCC);
        wr(`UFI_IX_IIR, 8'h87);
        @(posedge clk) tick_en <= 1'b0;
    endtask
    task automatic t_thr();
        int n;
        wr(`UFI_IX_IIR, 8'h00);
        wr(`UFI_IX_IIR, 8'h01);
        wr(`UFI_IX_IER, 8'h02);
        ckirq(1'b1);
        wr(`UFI_IX_BUF, 8'hA5);
        ckirq(1'b0);
        `CHK("txd", 8'hA5, txd)
        @(posedge clk) tick_en <= 1'b1;
        drain();
        repeat (200) @(posedge clk);
        ckirq(1'b0);
        for (n = 0; n < 300 && irq !== 1'b1; n++) @(negedge clk);
        `CHK("irq", 1'b1, irq)
        ck(`UFI_IX_IIR, 8'hC2);
        wr(`UFI_IX_BUF, 8'h01);
        wr(`UFI_IX_BUF, 8'h02);
        drain();
        ckirq(1'b1);
        @(posedge clk) tick_en <= 1'b0;
    endtask
    task automatic t_bus();
        wr(`UFI_IX_SCR, 8'h5A);
        ck(`UFI_IX_SCR, 8'h5A);
        wr(`UFI_IX_LTR, 8'hFF);
        `CHK("loopback", 1'b1, lb)
        ck(`UFI_IX_LTR, 8'h10);
        wr(`UFI_IX_CKG, 8'hFF);
        `CHK("clk_en", 1'b1, cken)
        wr(`UFI_IX_CKD, 8'h3C);
        `CHK("clk_div", 8'h3C, ckdv)
        wr(`UFI_IX_LCR, 8'h83);
        wr(`UFI_IX_BUF, 8'h12);
        wr(`UFI_IX_DLM, 8'h34);
        `CHK("baud_div", 16'h3412, bdiv)
        `CHK("line_ctrl", 8'h83, line_control)
        wr(`UFI_IX_LCR, 8'h03);
        wr(`UFI_IX_LSR, 8'h00);
        `CHK("bresp", `UFI_RESP_SLV, rs)
        rdx(6'h18);
        `CHK("rresp", `UFI_RESP_SLV, rs)
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        ck(`UFI_IX_IIR, 8'h01);
        `CHK("irq", 1'b0, irq)
        wr(`UFI_IX_LCR, 8'h03);
        t_trig();
        t_ls();
        t_tmo();
        t_thr();
        t_bus();
        wrap_up();
    end
endmodule // tb_top

// ==== verif/ufi_far.sv ====
/*
 Remote end of the serial line: hands in received characters and the
 receive baud tick, and drains the transmit stream when told to.
 Assumes one core clock shared with the block.
*/
`timescale 1ns/1ps
module ufi_far (
    input  wire logic i_clk,
    input  wire logic i_tick_en,
    input  wire logic i_tx_go,
    output logic      o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic [2:0] o_rx_err,
    output logic      o_tick,
    output logic      o_tx_ready,
    output logic      o_tx_idle
);
    logic ph_q = 1'b0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_rx_err = 3'h0;
    end
    // tick every second cycle keeps character times short
    always_ff @(posedge i_clk) begin
        ph_q <= !ph_q;
    end
    assign o_tick = i_tick_en && ph_q;
    assign o_tx_ready = i_tx_go;
    assign o_tx_idle = !i_tx_go;
    task automatic send(input logic [7:0] d, input logic [2:0] e);
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx_data <= d;
        o_rx_err <= e;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        // released lines must not keep the old value
        o_rx_data <= ~d;
        o_rx_err <= ~e;
        @(posedge i_clk);
    endtask
endmodule // ufi_far
